/* hw/scm_pkg.sv */
// Constants and types shared by the system command manager
package scm_pkg;
  // Register byte offsets
  localparam logic [4:0] SCM_OFS_CMD     = 5'h00;
  localparam logic [4:0] SCM_OFS_ERR     = 5'h04;
  localparam logic [4:0] SCM_OFS_FORCE   = 5'h08;
  localparam logic [4:0] SCM_OFS_KALIVE  = 5'h0c;
  localparam logic [4:0] SCM_OFS_MODE    = 5'h10;
  localparam logic [4:0] SCM_OFS_STAT    = 5'h14;
  localparam logic [4:0] SCM_OFS_IRQ_ST  = 5'h18;
  localparam logic [4:0] SCM_OFS_IRQ_MSK = 5'h1c;
  // Write answer codes shown in the status register
  localparam logic [1:0] SCM_RSP_OK      = 2'h0;
  localparam logic [1:0] SCM_RSP_RDONLY  = 2'h1;
  localparam logic [1:0] SCM_RSP_GENERIC = 2'h2;
  // Command error causes
  localparam logic [15:0] SCM_ERR_NONE     = 16'h0000;
  localparam logic [15:0] SCM_ERR_KALIVE   = 16'd1001;
  localparam logic [15:0] SCM_ERR_UNSAFE   = 16'h0002;
  localparam logic [15:0] SCM_ERR_POWERED  = 16'h0003;
  localparam logic [15:0] SCM_ERR_DONEFAIL = 16'h0004;
  // Operating mode shown while a motion command runs
  localparam logic [7:0]  SCM_MODE_TUNING  = 8'h81;
  // Keep-alive timeout
  localparam int          SCM_KALIVE_MS    = 2000;
  localparam int          SCM_CLK_MHZ      = 250;
  localparam int          SCM_KALIVE_CYC   = SCM_KALIVE_MS * 1000 * SCM_CLK_MHZ;
  // Interrupt status bit positions
  localparam int          SCM_IRQ_DONE     = 0;
  localparam int          SCM_IRQ_FAIL     = 1;
  localparam int          SCM_IRQ_KALIVE   = 2;
  localparam int          SCM_IRQ_W        = 3;

  // Drive-side conditions checked for safety
  typedef struct packed {
    logic drive_disabled;
    logic outs_generic;
    logic outs_off;
    logic capture_stopped;
  } scm_safe_type;

  // Command class lookup result
  typedef struct packed {
    logic needs_safety;
    logic needs_kalive;
    logic is_motion;
  } scm_class_type;

  // Avalon-MM slave request
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } scm_avm_req_type;
endpackage

/* hw/scm_classify.sv */
// Command code classifier for safety and keep-alive needs
`timescale 1ns/1ns
module scm_classify (
  // Command code in
  input  wire logic [15:0]           code,
  // Class out
  output scm_pkg::scm_class_type     cls
);
  import scm_pkg::*;

  // Decode command code into classes
  always_comb begin
    cls = '0;
    unique case (code)
      16'd2200, 16'd2201, 16'd2250, 16'd2300,
      16'd5000, 16'd5001, 16'd5100, 16'd6000,
      16'd8000, 16'd8100: begin
        cls.needs_safety = 1'b1;
      end
      16'd1001, 16'd1002, 16'd1003: begin
        cls.needs_kalive = 1'b1;
        cls.is_motion    = 1'b1;
      end
      16'd1010, 16'd1015, 16'd1020, 16'd1030, 16'd1040, 16'd1050: begin
        cls.needs_kalive = 1'b1;
        cls.is_motion    = 1'b1;
      end
      default: begin
        cls = '0;
      end
    endcase
  end
endmodule

/* hw/scm_top.sv */
// System command manager: accepts, runs and supervises host commands
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ns
module scm_top #(
  parameter int KALIVE_CYC = scm_pkg::SCM_KALIVE_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // Drive state inputs (pins; safety, done and fail synchronised here)
  input  wire scm_pkg::scm_safe_type  safe_in,
  input  wire logic                   cmd_done_in,
  input  wire logic                   cmd_fail_in,
  input  wire logic                   power_enable_req,
  // Drive control outputs
  output logic                        cmd_start,
  output logic [15:0]                 cmd_active_code,
  output logic                        force_safety,
  output logic                        power_enable_ok,
  output logic                        cmd_abort,
  output logic [7:0]                  operating_mode_readback,
  // Interrupt
  output logic                        irq
);
  import scm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FORCE, ST_RUN} scm_state_type;

  typedef struct packed {
    scm_state_type           st;
    logic [15:0]             cmd;
    logic [15:0]             err;
    logic                    force_en;
    logic [7:0]              mode_sel;
    logic [1:0]              rsp;
    logic [31:0]             kcnt;
    logic [SCM_IRQ_W-1:0]    ist;
    logic [SCM_IRQ_W-1:0]    imsk;
    logic [31:0]             rdata;
    logic                    wait_n;
    logic                    start;
    logic                    abort;
    logic                    pwr_ok;
    logic                    irq;
    logic [5:0]              s1;
    logic [5:0]              s2;
  } scm_reg_type;

  scm_reg_type   r_q;
  scm_reg_type   r_d;
  scm_class_type new_cls;
  scm_class_type run_cls;
  scm_safe_type  safe_s;
  logic          done_s;
  logic          fail_s;
  logic          pwr_req_s;

  // Class of written code and of the running code
  scm_classify u_cls_new (
    .code (avs_writedata[15:0]),
    .cls  (new_cls)
  );
  scm_classify u_cls_run (
    .code (r_q.cmd),
    .cls  (run_cls)
  );

  // Synchronised pin views, read only from the second stage; power request taken straight from its pin
  assign safe_s    = r_q.s2[5:2];
  assign done_s    = r_q.s2[1];
  assign fail_s    = r_q.s2[0];
  assign pwr_req_s = power_enable_req;

  // Next-state logic
  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic safe_ok;
    acc     = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    safe_ok = 1'b0;
    r_d       = r_q;
    r_d.s1    = {safe_in, cmd_done_in, cmd_fail_in};
    r_d.s2    = r_q.s1;
    r_d.start = 1'b0;
    r_d.abort = 1'b0;
    // One wait cycle per access: answer on the second edge.
    // Read data is loaded at the first edge so it stands at the taking edge
    acc = (avs_read || avs_write) && !r_q.wait_n;
    wr  = avs_write && r_q.wait_n;
    rd  = avs_read && !r_q.wait_n;
    r_d.wait_n = acc;
    safe_ok = safe_s.drive_disabled && safe_s.outs_generic &&
              safe_s.outs_off && safe_s.capture_stopped;

    // Command progress
    unique case (r_q.st)
      ST_IDLE: begin
      end
      ST_FORCE: begin
        if (safe_ok) begin
          r_d.st    = ST_RUN;
          r_d.start = 1'b1;
        end
      end
      ST_RUN: begin
        if (run_cls.needs_kalive) begin
          r_d.kcnt = r_q.kcnt + 32'd1;
        end
        if (run_cls.needs_kalive && r_q.kcnt >= 32'(KALIVE_CYC)) begin
          r_d.st    = ST_IDLE;
          r_d.cmd   = '0;
          r_d.err   = SCM_ERR_KALIVE;
          r_d.abort = 1'b1;
          r_d.ist[SCM_IRQ_KALIVE] = 1'b1;
        end else if (done_s) begin
          // code returns to zero on finish
          r_d.st  = ST_IDLE;
          r_d.cmd = '0;
          r_d.err = fail_s ? SCM_ERR_DONEFAIL : SCM_ERR_NONE;
          r_d.ist[SCM_IRQ_DONE] = 1'b1;
          if (fail_s) begin
            r_d.ist[SCM_IRQ_FAIL] = 1'b1;
          end
        end
      end
    endcase

    // Register writes
    if (wr) begin
      unique case (avs_address)
        SCM_OFS_CMD: begin
          if (r_q.st != ST_IDLE) begin
            r_d.rsp = SCM_RSP_RDONLY;
          end else if (avs_writedata[15:0] == '0) begin
            r_d.rsp = SCM_RSP_OK;
          end else if (new_cls.needs_safety && !safe_ok &&
                       !r_q.force_en) begin
            r_d.rsp = SCM_RSP_GENERIC;
            r_d.err = SCM_ERR_UNSAFE;
          end else begin
            r_d.rsp  = SCM_RSP_OK;
            r_d.cmd  = avs_writedata[15:0];
            r_d.err  = SCM_ERR_NONE;
            r_d.kcnt = '0;
            if (new_cls.needs_safety && !safe_ok) begin
              r_d.st = ST_FORCE;
            end else begin
              r_d.st    = ST_RUN;
              r_d.start = 1'b1;
            end
          end
        end
        SCM_OFS_FORCE: begin
          r_d.force_en = avs_writedata[0];
        end
        SCM_OFS_KALIVE: begin
          if (r_q.st == ST_RUN && avs_writedata[15:0] == r_q.cmd &&
              r_d.st == ST_RUN) begin
            r_d.kcnt = '0;
          end
        end
        SCM_OFS_MODE: begin
          if (!(r_q.st != ST_IDLE && run_cls.is_motion)) begin
            r_d.mode_sel = avs_writedata[7:0];
          end
        end
        SCM_OFS_IRQ_ST: begin
          // Write one to clear; new events set above win on bits that were clear
          r_d.ist = (r_q.ist & ~avs_writedata[SCM_IRQ_W-1:0]) |
                    (r_d.ist & ~r_q.ist);
        end
        SCM_OFS_IRQ_MSK: begin
          r_d.imsk = avs_writedata[SCM_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped reads return zero
    r_d.rdata = '0;
    if (rd) begin
      unique case (avs_address)
        SCM_OFS_CMD:     r_d.rdata = {16'h0000, r_q.cmd};
        SCM_OFS_ERR:     r_d.rdata = {16'h0000, r_q.err};
        SCM_OFS_FORCE:   r_d.rdata = {31'h0, r_q.force_en};
        SCM_OFS_MODE:    r_d.rdata = {24'h0, r_q.mode_sel};
        SCM_OFS_STAT:    r_d.rdata = {27'h0, r_q.st, r_q.rsp, safe_ok};
        SCM_OFS_IRQ_ST:  r_d.rdata = {29'h0, r_q.ist};
        SCM_OFS_IRQ_MSK: r_d.rdata = {29'h0, r_q.imsk};
        default:         r_d.rdata = '0;
      endcase
    end

    // no power enable while code nonzero
    r_d.pwr_ok = pwr_req_s && (r_d.cmd == '0);
    r_d.irq    = |(r_d.ist & r_d.imsk);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs from flip-flops, except avs_waitrequest, force_safety and operating_mode_readback, which are decoded
  assign avs_readdata    = r_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !r_q.wait_n;
  assign cmd_start       = r_q.start;
  assign cmd_active_code = r_q.cmd;
  assign force_safety    = (r_q.st == ST_FORCE);
  assign power_enable_ok = r_q.pwr_ok;
  assign cmd_abort       = r_q.abort;
  assign irq             = r_q.irq;
  // tuning mode shown while motion command runs
  assign operating_mode_readback =
    (r_q.st != ST_IDLE && run_cls.is_motion) ? SCM_MODE_TUNING
                                              : r_q.mode_sel;

  a_code_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (r_q.st == ST_RUN && done_s && r_d.st == ST_IDLE) |=> (r_q.cmd == '0))
    else $error("command code not cleared");
  a_power_block: assert property (@(posedge clk) disable iff (!rst_n)
    (r_q.cmd != '0) |-> !power_enable_ok)
    else $error("power enable while command busy");
  a_busy_reject: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_write && r_q.wait_n && avs_address == SCM_OFS_CMD &&
     r_q.st != ST_IDLE) |=> (r_q.rsp == SCM_RSP_RDONLY &&
      (r_q.cmd == $past(r_q.cmd) || r_q.cmd == '0)))
    else $error("busy command write not refused");
  a_kalive_err: assert property (@(posedge clk) disable iff (!rst_n)
    (r_q.st == ST_RUN && run_cls.needs_kalive &&
     r_q.kcnt >= 32'(KALIVE_CYC)) |=> (r_q.err == SCM_ERR_KALIVE && cmd_abort))
    else $error("keep-alive timeout not reported");
  a_mode_tuning: assert property (@(posedge clk) disable iff (!rst_n)
    (r_q.st == ST_RUN && run_cls.is_motion) |->
      operating_mode_readback == SCM_MODE_TUNING)
    else $error("mode readback not tuning");
  a_unsafe_rej: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_write && r_q.wait_n && avs_address == SCM_OFS_CMD &&
     r_q.st == ST_IDLE && new_cls.needs_safety && !r_q.force_en &&
     !(safe_s.drive_disabled && safe_s.outs_generic && safe_s.outs_off &&
       safe_s.capture_stopped)) |=>
      (r_q.rsp == SCM_RSP_GENERIC && r_q.err == SCM_ERR_UNSAFE))
    else $error("unsafe command not refused");
  a_accept_run: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(r_q.st) == ST_IDLE && r_q.st == ST_RUN) |-> cmd_start)
    else $error("accepted command did not start");
  a_timer_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (r_q.st == ST_IDLE) |=> ($stable(r_q.kcnt) || r_q.kcnt == '0))
    else $error("keep-alive timer ran while idle");
endmodule

/* bench/scm_drive_model.sv */
// Drive-side model: settles safety conditions and ends commands
`timescale 1ns/1ns
module scm_drive_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // From the manager
  input  wire logic             force_safety,
  input  wire logic [15:0]      cmd_active_code,
  // Bench controls
  input  wire logic             manual_safe,
  input  wire logic             auto_done,
  // To the manager
  output scm_pkg::scm_safe_type safe_in,
  output logic                  cmd_done_in,
  output logic                  cmd_fail_in
);
  import scm_pkg::*;
  logic [7:0] run_q;

  // Commands never fail on the drive side here
  assign cmd_fail_in = 1'b0;

  // Safety follows forcing or manual setup, run length counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_in     <= '0;
      run_q       <= 8'h00;
      cmd_done_in <= 1'b0;
    end else begin
      safe_in     <= {4{force_safety | manual_safe}};
      run_q       <= (cmd_active_code != 16'h0000) ? run_q + 8'h01 : 8'h00;
      cmd_done_in <= auto_done && (run_q == 8'h14);
    end
  end
endmodule

/* bench/tb_system_command_manager.sv */
// Self-checking bench for the system command manager
`timescale 1ns/1ns
module tb_system_command_manager;
  import scm_pkg::*;
  localparam int KC = 100;
  localparam logic [15:0] SAFE_CODES [10] = '{16'h0898, 16'h0899,
    16'h08ca, 16'h08fc, 16'h1388, 16'h1389, 16'h13ec, 16'h1770,
    16'h1f40, 16'h1fa4};
  localparam logic [15:0] KA_CODES [9] = '{16'h03e9, 16'h03ea, 16'h03eb,
    16'h03f2, 16'h03f7, 16'h03fc, 16'h0406, 16'h0410, 16'h041a};
  logic          clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]    avs_address;
  logic [31:0]   avs_writedata, avs_readdata, rdata;
  scm_safe_type  safe_in;
  logic          cmd_done_in, cmd_fail_in, power_enable_req, cmd_start;
  logic          force_safety, power_enable_ok, cmd_abort, irq, irq_a;
  logic          manual_safe, auto_done;
  logic [15:0]   cmd_active_code;
  logic [7:0]    operating_mode_readback;
  int            bad_count, n_tests;

  scm_top #(.KALIVE_CYC(KC)) i_dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .safe_in(safe_in), .cmd_done_in(cmd_done_in),
    .cmd_fail_in(cmd_fail_in), .power_enable_req(power_enable_req),
    .cmd_start(cmd_start), .cmd_active_code(cmd_active_code),
    .force_safety(force_safety), .power_enable_ok(power_enable_ok),
    .cmd_abort(cmd_abort),
    .operating_mode_readback(operating_mode_readback), .irq(irq));

  scm_drive_model i_drive (.clk(clk), .rst_n(rst_n),
    .force_safety(force_safety), .cmd_active_code(cmd_active_code),
    .manual_safe(manual_safe), .auto_done(auto_done), .safe_in(safe_in),
    .cmd_done_in(cmd_done_in), .cmd_fail_in(cmd_fail_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus access; request held until waitrequest is seen low
  task automatic acc(input logic [4:0] a, input logic wr,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      bad_count++;
      wrap_up();
    end
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a);
    acc(a, 1'b0, 32'h0);
  endtask

  // Bounded wait: 0 start, 1 abort, 2 forcing
  task automatic wait_for(input int s);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if ((s == 0 && cmd_start === 1'b1) || (s == 1 && cmd_abort === 1'b1)
          || (s == 2 && force_safety === 1'b1)) break;
    end
    chk("wait event", i < 400, 1'b1);
  endtask

  // Host polls the command code until it reads zero
  task automatic poll_idle;
    int i;
    for (i = 0; i < 100; i++) begin
      rd(SCM_OFS_CMD);
      if (rdata === 32'h0) break;
    end
    chk("cmd idle", i < 100, 1'b1);
  endtask

  // Hang guard
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {avs_read, avs_write, power_enable_req, manual_safe} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    auto_done = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(SCM_OFS_CMD);
    chk("cmd reset", rdata, 32'h0);
    rd(SCM_OFS_ERR);
    chk("err reset", rdata, 32'h0);
    power_enable_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("power idle", power_enable_ok, 1'b1);
    foreach (SAFE_CODES[k]) begin
      wr(SCM_OFS_CMD, {16'h0, SAFE_CODES[k]});
      rd(SCM_OFS_STAT);
      chk("rsp unsafe", rdata[2:1], SCM_RSP_GENERIC);
      rd(SCM_OFS_ERR);
      chk("err unsafe", rdata, SCM_ERR_UNSAFE);
    end
    wr(SCM_OFS_FORCE, 32'h1);
    wr(SCM_OFS_CMD, 32'h0898);
    wait_for(2);
    wait_for(0);
    chk("active code", cmd_active_code, 16'h0898);
    repeat (2) @(posedge clk);
    chk("power busy", power_enable_ok, 1'b0);
    wr(SCM_OFS_CMD, 32'h0899);
    rd(SCM_OFS_STAT);
    chk("rsp busy", rdata[2:1], SCM_RSP_RDONLY);
    poll_idle();
    rd(SCM_OFS_ERR);
    chk("err ok", rdata, SCM_ERR_NONE);
    wr(SCM_OFS_FORCE, 32'h0);
    manual_safe <= 1'b1;
    repeat (4) @(posedge clk);
    wr(SCM_OFS_CMD, 32'h1388);
    rd(SCM_OFS_STAT);
    chk("rsp manual", rdata[2:1], SCM_RSP_OK);
    poll_idle();
    manual_safe <= 1'b0;
    wr(SCM_OFS_MODE, 32'h3);
    repeat (2) @(posedge clk);
    chk("mode idle", operating_mode_readback, 8'h03);
    auto_done <= 1'b0;
    wr(SCM_OFS_FORCE, 32'h1);
    foreach (KA_CODES[k]) begin
      wr(SCM_OFS_CMD, {16'h0, KA_CODES[k]});
      wait_for(0);
      chk("no forcing", force_safety, 1'b0);
      if (k == 0) begin
        chk("mode tuning", operating_mode_readback, SCM_MODE_TUNING);
        wr(SCM_OFS_MODE, 32'h5);
        repeat (3) begin
          repeat (60) @(posedge clk);
          wr(SCM_OFS_KALIVE, {16'h0, KA_CODES[k]});
        end
        chk("kept alive", cmd_active_code, KA_CODES[k]);
      end
      wait_for(1);
      rd(SCM_OFS_ERR);
      chk("err kalive", rdata, SCM_ERR_KALIVE);
      poll_idle();
    end
    chk("mode kept", operating_mode_readback, 8'h03);
    rd(SCM_OFS_IRQ_ST);
    chk("irq kalive", rdata[SCM_IRQ_KALIVE], 1'b1);
    wr(SCM_OFS_IRQ_MSK, 32'h0);
    repeat (2) @(posedge clk);
    irq_a = irq;
    wr(SCM_OFS_IRQ_MSK, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq mask", irq_a ^ irq, 1'b1);
    wr(SCM_OFS_IRQ_ST, 32'h7);
    rd(SCM_OFS_IRQ_ST);
    chk("irq clear", rdata, 32'h0);
    chk("irq low", irq, 1'b0);
    chk("power back", power_enable_ok, 1'b1);
    wrap_up();
  end
endmodule
